/* serial_ctrl_params.svh */
`ifndef SERIAL_CTRL_PARAMS_SVH
`define SERIAL_CTRL_PARAMS_SVH
// Register offsets
`define OFS_LINE_FMT 3'h0
`define OFS_IRQ_DIR 3'h1
`define OFS_ERR_IRQ 3'h2
`define OFS_STATUS 3'h3
`define OFS_DATA 3'h4
`define OFS_BAUD 3'h5
`define OFS_BRK_CTL 3'h6
// Reset values
`define RST_CTRL 8'h00
`define RST_STATUS 8'hc0
`define RST_BAUD 8'h1a
// Oversampling: RT cycles 1..16 map to counts 0..15
`define RT_LAST 4'hf
`define RT_S1 4'h7
`define RT_S2 4'h8
`define RT_S3 4'h9
// Idle detection lengths in RT cycles (10 or 11 bit times)
`define IDLE_SHORT 8'ha0
`define IDLE_LONG 8'hb0
`define BITS_SHORT 4'ha
`define BITS_LONG 4'hb
`endif

/* serial_ctrl_pkg.sv */
package serial_ctrl_pkg;
    typedef struct packed {
        logic loopbackSel;
        logic moduleOn;
        logic txPolarityInvert;
        logic charLen9;
        logic wakeOnMark;
        logic idleCountStartSel;
        logic parityOn;
        logic parityOddSel;
    } line_format_t;
    typedef struct packed {
        logic txEmptyIrqEn;
        logic txDoneIrqEn;
        logic rxFullIrqEn;
        logic idleIrqEn;
        logic txOn;
        logic rxOn;
        logic rxStandby;
        logic sendBreak;
    } irq_dir_t;
    typedef struct packed {
        logic rxBit8;
        logic txBit8;
        logic [1:0] spare;
        logic overrunIrqEn;
        logic noiseIrqEn;
        logic framingIrqEn;
        logic parityIrqEn;
    } err_irq_t;
    typedef struct packed {
        logic txEmptyFlag;
        logic txDoneFlag;
        logic rxFullFlag;
        logic idleFlag;
        logic overrunFlag;
        logic noiseFlag;
        logic framingErrFlag;
        logic parityErrFlag;
    } status_t;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_START = 3'b010,
        RX_BITS = 3'b100
    } rx_state_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SHIFT = 2'b10
    } tx_state_t;
endpackage

/* serial_ctrl.sv */
// Contract
// RQ1 - Overrun sets flag, older character kept, new one dropped
// RQ2 - Overrun raises error request only with its enable set
// RQ3 - Noise in start, data or stop bits sets flag; gated by enable
// RQ4 - Zero at stop bit sets framing flag; gated by enable
// RQ5 - Parity mismatch sets parity flag; gated by enable
// RQ6 - Module keeps running in wait; enabled requests wake processor
// RQ7 - Stop mode halts module, registers preserved, resumes on exit
// RQ8 - Break with clear allowed lets software clear status; stays cleared
// RQ9 - Break with clear blocked protects status; armed clear completes after
// RQ10 - Enabled module drives transmit pin as output
// RQ11 - Enabled module makes receive pin an input
// RQ12 - Loopback disconnects receive pin, feeds transmitter to receiver
// RQ13 - Module enable gates block; clearing sets empty and done flags
// RQ14 - Inversion flips every transmitted level
// RQ15 - Length bit selects 9-bit or 8-bit characters
// RQ16 - One start, one stop bit; 10 or 11 bit frames
// RQ17 - Wake select: address mark when set, idle line when clear
// RQ18 - Idle count starts after stop bit when set, start bit when clear
// RQ19 - Parity sits in character MSB, generated and checked there
// RQ20 - Parity type: odd when set, even when clear
// RQ21 - Empty, done, full flags gated by their own enables
// RQ22 - Reset clears first control register and interrupt enables
// RQ23 - Idle enable lets idle flag raise receiver request
// RQ24 - Error request is OR of each flag AND its enable
`timescale 1ns/100ps
`include "serial_ctrl_params.svh"
module serial_ctrl (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // System state
    input wire logic stopMode,
    input wire logic breakState,
    // Shared port pins and their port-side settings
    input wire logic txPortData,
    input wire logic txPinDirectionBit,
    input wire logic rxPortData,
    input wire logic rxPinDirectionBit,
    input wire logic rxPortPinIn,
    output logic txPortPinOut,
    output logic txPortPinOe,
    output logic rxPortPinOut,
    output logic rxPortPinOe,
    // Requests
    output logic txIrq,
    output logic rxIrq,
    output logic errIrq,
    output logic wakeReq
);
    serial_ctrl_pkg::line_format_t fmt_r;
    serial_ctrl_pkg::irq_dir_t ctl2_r;
    serial_ctrl_pkg::err_irq_t ctl3_r;
    serial_ctrl_pkg::status_t stat_r, armed_r;
    serial_ctrl_pkg::rx_state_t rxState_r;
    serial_ctrl_pkg::tx_state_t txState_r;
    logic [7:0] dataRx_r, txBuf_r, baudDiv_r, baudCnt_r, idleCnt_r;
    logic [7:0] regRdData_nxt;
    logic breakClearAllow_r, idleArmed_r, rxNoise_r;
    logic [3:0] rxRt_r, txRt_r, rxBitIdx_r, txBitCnt_r;
    logic [1:0] samp_r;
    logic [8:0] rxShift_r;
    logic [10:0] txShift_r;
    logic rtTick, rxIn, txLine, maj, noisy, clrOk, rxDone, idleHit;
    logic [3:0] frameBits;
    logic [8:0] rxChar, txChar;
    logic [7:0] idleLen;
    logic rxMsb, rxParBad, deliver, statRd, dataRd, dataWr;

    assign statRd = regRead && regAddr == `OFS_STATUS;
    assign dataRd = regRead && regAddr == `OFS_DATA;
    assign dataWr = regWrite && regAddr == `OFS_DATA;
    // Break blocks status changes from software unless explicitly allowed
    assign clrOk = !breakState || breakClearAllow_r; // RQ8 RQ9
    assign frameBits = fmt_r.charLen9 ? `BITS_LONG : `BITS_SHORT; // RQ16
    assign idleLen = fmt_r.charLen9 ? `IDLE_LONG : `IDLE_SHORT;

    // Baud generator; halts in stop mode and when disabled
    assign rtTick = fmt_r.moduleOn && !stopMode && baudCnt_r == 8'h00; // RQ7 RQ13
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            baudCnt_r <= 8'h00;
        end else if (!fmt_r.moduleOn) begin
            baudCnt_r <= 8'h00;
        end else if (!stopMode) begin
            baudCnt_r <= rtTick ? baudDiv_r : baudCnt_r - 8'h01;
        end
    end

    // Control registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fmt_r <= `RST_CTRL; // RQ22
            ctl2_r <= `RST_CTRL; // RQ22 RQ23
            ctl3_r <= `RST_CTRL;
            baudDiv_r <= `RST_BAUD;
            breakClearAllow_r <= 1'b0;
        end else begin
            if (regWrite) begin
                unique case (regAddr)
                    `OFS_LINE_FMT: fmt_r <= regWrData;
                    `OFS_IRQ_DIR: begin
                        ctl2_r <= regWrData;
                        // Enables of the halves only move while the module is on
                        if (!fmt_r.moduleOn) begin
                            ctl2_r.txOn <= ctl2_r.txOn;
                            ctl2_r.rxOn <= ctl2_r.rxOn;
                        end
                    end
                    `OFS_ERR_IRQ: ctl3_r <= {ctl3_r.rxBit8, regWrData[6], 2'b00, regWrData[3:0]};
                    `OFS_BAUD: baudDiv_r <= regWrData;
                    `OFS_BRK_CTL: breakClearAllow_r <= regWrData[7];
                    default: ;
                endcase
            end
            // Hardware wake clears standby unless software writes it now
            if ((deliver && fmt_r.wakeOnMark && rxMsb) || (idleHit && !fmt_r.wakeOnMark)) begin
                if (!(regWrite && regAddr == `OFS_IRQ_DIR)) begin
                    ctl2_r.rxStandby <= 1'b0; // RQ17
                end
            end
            if (rxDone && !(ctl2_r.rxStandby && !(fmt_r.wakeOnMark && rxMsb)) && !stat_r.rxFullFlag) begin
                ctl3_r.rxBit8 <= fmt_r.charLen9 ? rxChar[8] : rxChar[7];
            end
        end
    end

    // Receive path; loopback cuts the pin off the receiver
    assign txLine = txState_r == serial_ctrl_pkg::TX_SHIFT ? txShift_r[0] : 1'b1;
    assign rxIn = fmt_r.loopbackSel ? txLine : rxPortPinIn; // RQ12
    assign maj = (samp_r[1] & samp_r[0]) | (samp_r[1] & rxIn) | (samp_r[0] & rxIn);
    assign noisy = !((samp_r[1] == samp_r[0]) && (samp_r[0] == rxIn)); // RQ3
    assign rxDone = rtTick && rxState_r == serial_ctrl_pkg::RX_BITS && rxRt_r == `RT_S3
        && rxBitIdx_r == frameBits - 4'h2;
    assign rxChar = fmt_r.charLen9 ? rxShift_r : {1'b0, rxShift_r[8:1]}; // RQ15
    assign rxMsb = fmt_r.charLen9 ? rxChar[8] : rxChar[7];
    assign rxParBad = fmt_r.parityOn && ((^rxChar) ^ fmt_r.parityOddSel); // RQ19 RQ20
    // Standby drops characters unless an address mark wakes the receiver
    assign deliver = rxDone && (!ctl2_r.rxStandby || (fmt_r.wakeOnMark && rxMsb)); // RQ17

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rxState_r <= serial_ctrl_pkg::RX_IDLE;
            rxRt_r <= 4'h0;
            rxBitIdx_r <= 4'h0;
            samp_r <= 2'b11;
            rxShift_r <= 9'h000;
            rxNoise_r <= 1'b0;
        end else if (!ctl2_r.rxOn) begin
            rxState_r <= serial_ctrl_pkg::RX_IDLE;
        end else if (rtTick) begin
            rxRt_r <= rxRt_r + 4'h1;
            if (rxRt_r == `RT_S1 || rxRt_r == `RT_S2) begin
                samp_r <= {samp_r[0], rxIn};
            end
            unique case (rxState_r)
                serial_ctrl_pkg::RX_IDLE: begin
                    rxRt_r <= 4'h1;
                    rxNoise_r <= 1'b0;
                    if (!rxIn) begin
                        rxState_r <= serial_ctrl_pkg::RX_START;
                    end
                end
                serial_ctrl_pkg::RX_START: begin
                    if (rxRt_r == `RT_S3) begin
                        rxNoise_r <= noisy; // RQ3
                        // A start bit that reads mostly high was a glitch or a framing tail
                        if (maj) begin
                            rxState_r <= serial_ctrl_pkg::RX_IDLE;
                        end
                    end
                    if (rxRt_r == `RT_LAST) begin
                        rxBitIdx_r <= 4'h0;
                        rxState_r <= serial_ctrl_pkg::RX_BITS;
                    end
                end
                serial_ctrl_pkg::RX_BITS: begin
                    if (rxRt_r == `RT_S3) begin
                        rxNoise_r <= rxNoise_r | noisy; // RQ3
                        if (rxBitIdx_r < frameBits - 4'h2) begin
                            rxShift_r <= {maj, rxShift_r[8:1]};
                        end else begin
                            rxState_r <= serial_ctrl_pkg::RX_IDLE;
                        end
                    end
                    if (rxRt_r == `RT_LAST) begin
                        rxBitIdx_r <= rxBitIdx_r + 4'h1;
                    end
                end
                default: rxState_r <= serial_ctrl_pkg::RX_IDLE;
            endcase
        end
    end

    // Idle counting in RT cycles of ones
    assign idleHit = rtTick && idleCnt_r == idleLen - 8'h01 && rxIn;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            idleCnt_r <= 8'h00;
        end else if (!ctl2_r.rxOn || (rtTick && !rxIn)) begin
            idleCnt_r <= 8'h00;
        end else if (rtTick && idleCnt_r != idleLen) begin
            // Counting after the stop bit waits for the frame to end
            if (fmt_r.idleCountStartSel ? rxState_r == serial_ctrl_pkg::RX_IDLE
                                        : rxState_r != serial_ctrl_pkg::RX_START) begin
                idleCnt_r <= idleCnt_r + 8'h01; // RQ18
            end else begin
                idleCnt_r <= 8'h00;
            end
        end
    end

    // Transmitter
    always_comb begin
        txChar = {ctl3_r.txBit8, txBuf_r};
        if (fmt_r.parityOn && fmt_r.charLen9) begin
            txChar[8] = (^txBuf_r) ^ fmt_r.parityOddSel; // RQ19 RQ20
        end else if (fmt_r.parityOn) begin
            txChar[7] = (^txBuf_r[6:0]) ^ fmt_r.parityOddSel; // RQ19
        end
        if (!fmt_r.charLen9) begin
            txChar[8] = 1'b1;
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            txState_r <= serial_ctrl_pkg::TX_IDLE;
            txShift_r <= 11'h7ff;
            txRt_r <= 4'h0;
            txBitCnt_r <= 4'h0;
        end else if (!fmt_r.moduleOn) begin
            txState_r <= serial_ctrl_pkg::TX_IDLE;
        end else if (rtTick) begin
            unique case (txState_r)
                serial_ctrl_pkg::TX_IDLE: begin
                    txRt_r <= 4'h0;
                    txBitCnt_r <= 4'h0;
                    if (ctl2_r.txOn && ctl2_r.sendBreak) begin
                        txShift_r <= 11'h000;
                        txState_r <= serial_ctrl_pkg::TX_SHIFT;
                    end else if (ctl2_r.txOn && !stat_r.txEmptyFlag) begin
                        txShift_r <= {1'b1, txChar, 1'b0}; // RQ16
                        txState_r <= serial_ctrl_pkg::TX_SHIFT;
                    end
                end
                serial_ctrl_pkg::TX_SHIFT: begin
                    txRt_r <= txRt_r + 4'h1;
                    if (txRt_r == `RT_LAST) begin
                        txShift_r <= {1'b1, txShift_r[10:1]};
                        txBitCnt_r <= txBitCnt_r + 4'h1;
                        if (txBitCnt_r == frameBits - 4'h1) begin
                            txState_r <= serial_ctrl_pkg::TX_IDLE;
                        end
                    end
                end
                default: txState_r <= serial_ctrl_pkg::TX_IDLE;
            endcase
        end
    end

    // Status flags; hardware set wins over a software clear, except the done flag, which a data write holds off
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stat_r <= `RST_STATUS;
            armed_r <= 8'h00;
            dataRx_r <= 8'h00;
            txBuf_r <= 8'h00;
            idleArmed_r <= 1'b0;
        end else begin
            // Arm survives a protected break so the second step completes later
            if (statRd && clrOk) begin
                armed_r <= stat_r; // RQ9
            end
            if (dataRd && clrOk) begin
                stat_r.rxFullFlag <= stat_r.rxFullFlag & ~armed_r.rxFullFlag; // RQ8
                stat_r.idleFlag <= stat_r.idleFlag & ~armed_r.idleFlag;
                stat_r.overrunFlag <= stat_r.overrunFlag & ~armed_r.overrunFlag;
                stat_r.noiseFlag <= stat_r.noiseFlag & ~armed_r.noiseFlag;
                stat_r.framingErrFlag <= stat_r.framingErrFlag & ~armed_r.framingErrFlag;
                stat_r.parityErrFlag <= stat_r.parityErrFlag & ~armed_r.parityErrFlag;
                armed_r[5:0] <= 6'h00;
            end
            if (dataWr) begin
                txBuf_r <= regWrData;
                if (clrOk && armed_r.txEmptyFlag && fmt_r.moduleOn) begin
                    stat_r.txEmptyFlag <= 1'b0;
                    stat_r.txDoneFlag <= 1'b0;
                    armed_r.txEmptyFlag <= 1'b0;
                end
            end
            if (rtTick && txState_r == serial_ctrl_pkg::TX_IDLE && ctl2_r.txOn
                    && (ctl2_r.sendBreak || !stat_r.txEmptyFlag)) begin
                stat_r.txEmptyFlag <= 1'b1;
                stat_r.txDoneFlag <= 1'b0;
            end else if (txState_r == serial_ctrl_pkg::TX_IDLE && stat_r.txEmptyFlag && !dataWr) begin
                stat_r.txDoneFlag <= 1'b1;
            end
            if (!fmt_r.moduleOn) begin
                stat_r.txEmptyFlag <= 1'b1; // RQ13
                stat_r.txDoneFlag <= 1'b1; // RQ13
            end
            if (deliver) begin
                if (stat_r.rxFullFlag) begin
                    stat_r.overrunFlag <= 1'b1; // RQ1
                end else begin
                    dataRx_r <= rxChar[7:0];
                    stat_r.rxFullFlag <= 1'b1;
                    stat_r.noiseFlag <= rxNoise_r | noisy; // RQ3
                    stat_r.framingErrFlag <= !maj; // RQ4
                    stat_r.parityErrFlag <= rxParBad; // RQ5
                    idleArmed_r <= 1'b1;
                end
            end
            if (idleHit && idleArmed_r && !ctl2_r.rxStandby) begin
                stat_r.idleFlag <= 1'b1;
                idleArmed_r <= 1'b0;
            end
        end
    end

    // Read port
    always_comb begin
        unique case (regAddr)
            `OFS_LINE_FMT: regRdData_nxt = fmt_r;
            `OFS_IRQ_DIR: regRdData_nxt = ctl2_r;
            `OFS_ERR_IRQ: regRdData_nxt = ctl3_r;
            `OFS_STATUS: regRdData_nxt = stat_r;
            `OFS_DATA: regRdData_nxt = dataRx_r;
            `OFS_BAUD: regRdData_nxt = baudDiv_r;
            `OFS_BRK_CTL: regRdData_nxt = {breakClearAllow_r, 7'h00};
            default: regRdData_nxt = 8'h00;
        endcase
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= regRead ? regRdData_nxt : 8'h00;
        end
    end

    // Pins: the module takes both pins over while enabled
    assign txPortPinOut = fmt_r.moduleOn ? (txLine ^ fmt_r.txPolarityInvert) : txPortData; // RQ14
    assign txPortPinOe = fmt_r.moduleOn || txPinDirectionBit; // RQ10
    assign rxPortPinOut = rxPortData;
    assign rxPortPinOe = !fmt_r.moduleOn && rxPinDirectionBit; // RQ11

    // Requests
    assign txIrq = fmt_r.moduleOn && ((stat_r.txEmptyFlag && ctl2_r.txEmptyIrqEn)
        || (stat_r.txDoneFlag && ctl2_r.txDoneIrqEn)); // RQ13 RQ21
    assign rxIrq = !ctl2_r.rxStandby && ((stat_r.rxFullFlag && ctl2_r.rxFullIrqEn)
        || (stat_r.idleFlag && ctl2_r.idleIrqEn)); // RQ21 RQ23
    assign errIrq = (stat_r.overrunFlag && ctl3_r.overrunIrqEn) || (stat_r.noiseFlag && ctl3_r.noiseIrqEn)
        || (stat_r.framingErrFlag && ctl3_r.framingIrqEn)
        || (stat_r.parityErrFlag && ctl3_r.parityIrqEn); // RQ2 RQ3 RQ4 RQ5 RQ24
    assign wakeReq = txIrq || rxIrq || errIrq; // RQ6

    // Checks
    property p_overrun_keep;
        @(posedge clock) disable iff (!rstn) deliver && stat_r.rxFullFlag |=> stat_r.overrunFlag && $stable(dataRx_r);
    endproperty
    a_overrun_keep: assert property (p_overrun_keep) else $error("overrun lost old data"); // RQ1
    property p_or_gate;
        @(posedge clock) disable iff (!rstn)
        stat_r.overrunFlag && ctl3_r.overrunIrqEn |-> errIrq;
    endproperty
    a_or_gate: assert property (p_or_gate) else $error("overrun request missing"); // RQ2
    property p_err_quiet;
        @(posedge clock) disable iff (!rstn)
        ctl3_r[3:0] == 4'h0 |-> !errIrq;
    endproperty
    a_err_quiet: assert property (p_err_quiet) else $error("error request without enable"); // RQ24
    property p_stop_hold;
        @(posedge clock) disable iff (!rstn)
        stopMode && !regWrite && !regRead |=> $stable(stat_r) && $stable(rxState_r);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("state moved in stop"); // RQ7
    sequence s_arm_rx;
        statRd && clrOk && stat_r.rxFullFlag;
    endsequence
    sequence s_protected_read;
        dataRd && breakState && !breakClearAllow_r && !deliver && stat_r.rxFullFlag;
    endsequence
    property p_break_protect;
        @(posedge clock) disable iff (!rstn) s_arm_rx ##[1:8] s_protected_read |=> stat_r.rxFullFlag;
    endproperty
    a_break_protect: assert property (p_break_protect) else $error("status changed in break"); // RQ9
    property p_pins;
        @(posedge clock) disable iff (!rstn) fmt_r.moduleOn |-> txPortPinOe && !rxPortPinOe;
    endproperty
    a_pins: assert property (p_pins) else $error("pin ownership wrong"); // RQ10 RQ11
    property p_off_flags;
        @(posedge clock) disable iff (!rstn) !fmt_r.moduleOn |=> stat_r.txEmptyFlag && stat_r.txDoneFlag && !txIrq;
    endproperty
    a_off_flags: assert property (p_off_flags) else $error("disable left tx flags"); // RQ13
    property p_idle_level;
        @(posedge clock) disable iff (!rstn)
        fmt_r.moduleOn && txState_r == serial_ctrl_pkg::TX_IDLE |-> txPortPinOut == !fmt_r.txPolarityInvert;
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle level wrong"); // RQ14
    property p_frame_len;
        @(posedge clock) disable iff (!rstn) rxDone |-> rxBitIdx_r == (fmt_r.charLen9 ? 4'h9 : 4'h8);
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("stop bit at wrong position"); // RQ16
endmodule

/* serial_peer.sv */
`timescale 1ns/100ps
module serial_peer (
    // Clock
    input wire logic clock,
    // Line into the receive pin
    output logic line
);
    // Mark level between frames, one clock per RT tick at divisor 0
    initial line = 1'b1;
    task automatic sendFrame(input logic [10:0] frame, input int n, input logic noisy);
        for (int i = 0; i < n; i++) begin
            for (int c = 0; c < 16; c++) begin
                @(posedge clock);
                // One-clock glitch can hit only one of three samples
                line <= frame[i] ^ (noisy && i == 2 && c == 9);
            end
        end
        @(posedge clock);
        line <= 1'b1;
    endtask
endmodule

/* test_serial_ctrl.sv */
`timescale 1ns/100ps
module test_serial_ctrl;
    typedef struct {logic [7:0] fmt; logic [7:0] en; logic [10:0] frame; int n; logic noisy;
        logic [7:0] st; logic [7:0] dat; logic err;} row_t;
    logic clock = 1'b0, rstn = 1'b0, regWrite = 1'b0, regRead = 1'b0, breakState = 1'b0, stopMode = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00, regRdData, d;
    logic txPortPinOut, txPortPinOe, rxPortPinOe, txIrq, rxIrq, errIrq, wakeReq, rxLine;
    int failures = 0, nChecks = 0, cycles = 0;
    logic [7:0] rstVal[8] = '{8'h00, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h1a, 8'h00, 8'h00};
    // Received bit 8 and data are masked out of the reset check
    logic [7:0] rstMsk[8] = '{8'hff, 8'hff, 8'h7f, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff};
    row_t rows[8] = '{
        '{8'h40, 8'h00, {2'b01, 8'h96, 1'b0}, 10, 1'b0, 8'h20, 8'h96, 1'b0},
        '{8'h40, 8'h02, {2'b00, 8'h96, 1'b0}, 10, 1'b0, 8'h22, 8'h96, 1'b1},
        '{8'h42, 8'h01, {2'b01, 8'h83, 1'b0}, 10, 1'b0, 8'h21, 8'h83, 1'b1},
        '{8'h43, 8'h01, {2'b01, 8'h83, 1'b0}, 10, 1'b0, 8'h20, 8'h83, 1'b0},
        '{8'h40, 8'h04, {2'b01, 8'h96, 1'b0}, 10, 1'b1, 8'h24, 8'h96, 1'b1},
        '{8'h40, 8'h00, {2'b01, 8'h96, 1'b0}, 10, 1'b1, 8'h24, 8'h96, 1'b0},
        '{8'h50, 8'h00, {2'b11, 8'h5a, 1'b0}, 11, 1'b0, 8'h20, 8'h5a, 1'b0},
        '{8'h52, 8'h01, {2'b10, 8'h01, 1'b0}, 11, 1'b0, 8'h21, 8'h01, 1'b1}};
    serial_peer peer (.clock(clock), .line(rxLine));
    serial_ctrl DUT (.clock(clock), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .stopMode(stopMode), .breakState(breakState),
        .txPortData(1'b1), .txPinDirectionBit(1'b0), .rxPortData(1'b0), .rxPinDirectionBit(1'b1),
        .rxPortPinIn(rxLine), .txPortPinOut(txPortPinOut), .txPortPinOe(txPortPinOe), .rxPortPinOut(),
        .rxPortPinOe(rxPortPinOe), .txIrq(txIrq), .rxIrq(rxIrq), .errIrq(errIrq), .wakeReq(wakeReq));
    initial forever #10 clock = ~clock;
    task automatic results();
        $display("checks=%0d failures=%0d", nChecks, failures);
        if (failures == 0 && nChecks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 10000) begin
            failures++;
            results();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clock);
        regAddr <= a;
        regWrData <= v;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 v = regRdData;
    endtask
    task automatic rxWait();
        for (int k = 0; k < 64 && rxIrq !== 1'b1; k++) @(posedge clock);
        chk({6'h0, rxIrq, wakeReq}, 8'h03);
    endtask
    task automatic rxFrame(input logic [10:0] f, input int n, input logic noisy);
        peer.sendFrame(f, n, noisy);
        rxWait();
    endtask
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], d);
            chk(d & rstMsk[a], rstVal[a]);
        end
        chk({6'h0, txPortPinOe, rxPortPinOe}, 8'h01);
        wr(3'h5, 8'h00);
        wr(3'h0, 8'h40);
        wr(3'h1, 8'hac);
        chk({6'h0, txPortPinOe, rxPortPinOe}, 8'h02);
        foreach (rows[i]) begin
            wr(3'h0, rows[i].fmt);
            wr(3'h2, rows[i].en);
            rxFrame(rows[i].frame, rows[i].n, rows[i].noisy);
            rd(3'h3, d);
            chk(d & 8'h2f, rows[i].st);
            chk({7'h0, errIrq}, {7'h0, rows[i].err});
            rd(3'h4, d);
            chk(d, rows[i].dat);
            chk({6'h0, errIrq, rxIrq}, 8'h00);
        end
        wr(3'h0, 8'h40);
        wr(3'h2, 8'h00);
        rxFrame({2'b01, 8'h11, 1'b0}, 10, 1'b0);
        peer.sendFrame({2'b01, 8'h22, 1'b0}, 10, 1'b0);
        rd(3'h3, d);
        chk(d & 8'h2f, 8'h28);
        chk({7'h0, errIrq}, 8'h00);
        wr(3'h2, 8'h08);
        chk({7'h0, errIrq}, 8'h01);
        rd(3'h3, d);
        rd(3'h4, d);
        chk(d, 8'h11);
        // Clear armed before the break must finish after it
        rxFrame({2'b01, 8'h33, 1'b0}, 10, 1'b0);
        rd(3'h3, d);
        @(posedge clock) breakState <= 1'b1;
        rd(3'h4, d);
        rd(3'h3, d);
        chk(d & 8'h2f, 8'h20);
        @(posedge clock) breakState <= 1'b0;
        rd(3'h4, d);
        rd(3'h3, d);
        chk(d & 8'h2f, 8'h00);
        rxFrame({2'b01, 8'h44, 1'b0}, 10, 1'b0);
        wr(3'h6, 8'h80);
        @(posedge clock) breakState <= 1'b1;
        rd(3'h3, d);
        rd(3'h4, d);
        @(posedge clock) breakState <= 1'b0;
        rd(3'h3, d);
        chk(d & 8'h2f, 8'h00);
        @(posedge clock) stopMode <= 1'b1;
        rd(3'h0, d);
        chk(d, 8'h40);
        @(posedge clock) stopMode <= 1'b0;
        // Pin traffic must not reach the receiver in loop mode
        wr(3'h0, 8'hc0);
        fork
            peer.sendFrame({2'b01, 8'h00, 1'b0}, 10, 1'b0);
            wr(3'h4, 8'h6b);
        join
        rxWait();
        rd(3'h3, d);
        rd(3'h4, d);
        chk(d, 8'h6b);
        wr(3'h0, 8'h60);
        chk({7'h0, txPortPinOut}, 8'h00);
        wr(3'h0, 8'h40);
        chk({7'h0, txPortPinOut}, 8'h01);
        rd(3'h3, d);
        wr(3'h4, 8'h00);
        wr(3'h0, 8'h00);
        rd(3'h3, d);
        chk(d & 8'hc0, 8'hc0);
        chk({7'h0, txIrq}, 8'h00);
        results();
    end
endmodule
